// ==== include/rts_pkg.sv ====
// rts_pkg: constants and types of the rule table step sequencer
// assumes a single 100 MHz clock and no software register access
package rts_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned OP_CYCLE_NS   = 1000;
	localparam int unsigned OP_CYCLE_CLKS =
		(OP_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// table sizes
	// ------------------------------------------------------------
	localparam int unsigned STD_RULES = 32;
	localparam int unsigned EXP_RULES = 64;
	localparam int unsigned STD_ROWS  = 32;
	localparam int unsigned EXP_ROWS  = 64;

	// ------------------------------------------------------------
	// step numbers
	// ------------------------------------------------------------
	localparam int unsigned STEP_W      = 7;
	localparam logic [6:0]  STEP_ALWAYS = 7'h00;
	localparam logic [6:0]  STEP_FIRST  = 7'h01;
	localparam logic [6:0]  STEP_LAST   = 7'h40;
	localparam logic [6:0]  STEP_RST    = 7'h00;

	// ------------------------------------------------------------
	// block addresses and slot use
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W     = 10;
	localparam logic [9:0]  ADDR_FIRST = 10'h2bd;
	localparam logic [9:0]  ADDR_LAST  = 10'h384;
	localparam logic [9:0]  ADDR_RST   = 10'h2bd;
	localparam logic [2:0]  SLOTS_STD  = 3'h1;
	localparam logic [2:0]  SLOTS_ONE  = 3'h2;
	localparam logic [2:0]  SLOTS_BOTH = 3'h4;

	// ------------------------------------------------------------
	// modes and states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RTS_MODE_EVERY  = 2'h0,
		RTS_MODE_SWITCH = 2'h1,
		RTS_MODE_FIRST  = 2'h2,
		RTS_MODE_NEVER  = 2'h3
	} rts_mode_t;

	typedef enum logic [1:0] {
		RTS_IDLE = 2'b01,
		RTS_RUN  = 2'b10
	} rts_run_t;

endpackage : rts_pkg

// ==== include/rts_if.sv ====
// rts_if: signals between the sequencer core and its helpers
// assumes all three modules share one clock
`timescale 1ns/1ps
`default_nettype none
interface rts_if #(
	parameter int unsigned NR = 64,
	parameter int unsigned NC = 64,
	parameter int unsigned NA = 64
);
	logic [NC-1:0]         in_sig;
	logic [NR-1:0][NC-1:0] sel;
	logic [NR-1:0][NC-1:0] pol;
	logic [NR-1:0]         cond;
	logic [NR-1:0]         fire;
	logic [NR-1:0][NA-1:0] act_sel;
	logic [NR-1:0][NA-1:0] act_val;
	logic [NA-1:0]         act_old;
	logic [NA-1:0]         act_new;

	modport cond_mp (input in_sig, sel, pol, output cond);
	modport act_mp  (input fire, act_sel, act_val, act_old,
		output act_new);
	modport core_mp (output in_sig, sel, pol, fire, act_sel, act_val,
		act_old, input cond, act_new);
endinterface : rts_if
`default_nettype wire

// ==== hw/rts_cond.sv ====
// rts_cond: per-rule condition evaluation
// assumes masked selections arrive from the core
`timescale 1ns/1ps
`default_nettype none
module rts_cond #(
	parameter int unsigned NR = 64,
	parameter int unsigned NC = 64
) (
	rts_if.cond_mp bus
);
	// ------------------------------------------------------------
	// and of selected contacts
	// ------------------------------------------------------------
	genvar r;
	generate
		for (r = 0; r < NR; r++)
		begin : g_rule
			logic [NC-1:0] miss;
			logic          any_sel;
			assign miss    = bus.sel[r] & (bus.in_sig ^ bus.pol[r]);
			assign any_sel = |bus.sel[r];
			assign bus.cond[r] = any_sel & ~(|miss);
		end
	endgenerate
endmodule : rts_cond
`default_nettype wire

// ==== hw/rts_act.sv ====
// rts_act: resolves fired rules onto the action outputs
// assumes fire is zero on cycles that do not execute
`timescale 1ns/1ps
`default_nettype none
module rts_act #(
	parameter int unsigned NR = 64,
	parameter int unsigned NA = 64
) (
	rts_if.act_mp bus
);
	// ------------------------------------------------------------
	// per output, last writer wins
	// ------------------------------------------------------------
	genvar a;
	generate
		for (a = 0; a < NA; a++)
		begin : g_out
			always_comb
			begin
				bus.act_new[a] = bus.act_old[a];
				for (int r = 0; r < NR; r++)
				begin
					if (bus.fire[r] && bus.act_sel[r][a])
					begin
						bus.act_new[a] = bus.act_val[r][a];
					end
				end
			end
		end
	endgenerate
endmodule : rts_act
`default_nettype wire

// ==== hw/rts_top.sv ====
// rts_top: rule table step sequencer, one table
// assumes contacts and table contents come from logic on clk
//
// Contract
// - two-bit mode: every, switch, first, never
// - switch mode runs only while switch on
// - condition ands selected contacts, true or inverted
// - rule with no selected contacts never fires
// - actions once, on condition rising edge
// - 32 rules standard, 64 expanded
// - 32 or 64 condition and action rows
// - active rules evaluated together, actions merged per output bit
// - conflicting outputs take highest-numbered rule
// - action rows applied top to bottom
// - one numbered step active at once
// - rule may jump on true or false
// - unchanged step keeps evaluating every cycle
// - true jump after that rule's actions
// - entering step clears its rules' history
// - lowest-numbered requesting rule picks destination
// - step 00 evaluated every executed cycle
// - steps 01 to 64, ascending, gaps allowed
// - start activates step 00 and lowest step
// - new step first evaluated next cycle
// - tables at block addresses 701 to 900
// - expansion uses two or four slots
`timescale 1ns/1ps
`default_nettype none
module rts_top #(
	parameter int unsigned NR     = rts_pkg::EXP_RULES,
	parameter int unsigned NC     = rts_pkg::EXP_ROWS,
	parameter int unsigned NA     = rts_pkg::EXP_ROWS,
	parameter int unsigned OP_DIV = rts_pkg::OP_CYCLE_CLKS
) (
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	input  wire rts_pkg::rts_mode_t    exec_mode,
	input  wire logic                  run_control_switch,
	input  wire logic                  ctrl_start,
	input  wire logic                  rule_expand,
	input  wire logic                  row_expand,
	input  wire logic [9:0]            base_addr,
	input  wire logic [NC-1:0]         contact_in,
	input  wire logic [NR-1:0][NC-1:0] cond_sel,
	input  wire logic [NR-1:0][NC-1:0] cond_pol,
	input  wire logic [NR-1:0][NA-1:0] act_sel,
	input  wire logic [NR-1:0][NA-1:0] act_val,
	input  wire logic [NR-1:0][6:0]    rule_step,
	input  wire logic [NR-1:0]         then_en,
	input  wire logic [NR-1:0][6:0]    then_step,
	input  wire logic [NR-1:0]         else_en,
	input  wire logic [NR-1:0][6:0]    else_step,
	output logic      [NA-1:0]         act_q,
	output logic      [6:0]            step_q,
	output logic                       running_q,
	output logic                       exec_q,
	output logic      [NR-1:0]         fired_q,
	output logic      [2:0]            slots_q,
	output logic      [9:0]            next_addr_q,
	output logic                       addr_ok_q
);
	// ------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------
	localparam int unsigned DIV_W = $clog2(OP_DIV + 1);

	if (NR != rts_pkg::EXP_RULES || NC != rts_pkg::EXP_ROWS ||
		NA != rts_pkg::EXP_ROWS)
	begin : g_bad_size
		$error("rts_top: table must be sized for the expanded form");
	end
	if (OP_DIV < 1)
	begin : g_bad_div
		$error("rts_top: operation cycle divider below one");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DIV_W-1:0]  div;
		rts_pkg::rts_run_t run;
		logic              first_pend;
		logic [6:0]        step;
		logic [NR-1:0]     prev;
		logic [NA-1:0]     act;
		logic [NR-1:0]     fired;
		logic              exec;
		logic [2:0]        slots;
		logic [9:0]        next_addr;
		logic              addr_ok;
	} rts_state_t;

	rts_state_t s_q;
	rts_state_t s_d;

	rts_if #(.NR(NR), .NC(NC), .NA(NA)) ifc ();

	logic [NC-1:0] row_mask;
	logic [NR-1:0] rule_mask;
	logic [NR-1:0] active;
	logic [6:0]    low_step;
	logic [6:0]    eff_step;
	logic [NR-1:0] prev_eff;
	logic          tick;
	logic          enabled;
	logic          go;
	logic          jump;
	logic [6:0]    dest;
	logic [10:0]   addr_end;

	// ------------------------------------------------------------
	// table size masks
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NR; g++)
		begin : g_mask
			assign rule_mask[g] = rule_expand ||
				(g < rts_pkg::STD_RULES);
			assign row_mask[g] = row_expand ||
				(g < rts_pkg::STD_ROWS);
			assign ifc.sel[g]     = cond_sel[g] & row_mask;
			assign ifc.pol[g]     = cond_pol[g];
			assign ifc.act_sel[g] = act_sel[g] & row_mask;
			assign ifc.act_val[g] = act_val[g];
		end
	endgenerate

	assign ifc.in_sig  = contact_in;
	assign ifc.act_old = s_q.act;

	rts_cond #(.NR(NR), .NC(NC)) u_cond (
		.bus (ifc.cond_mp)
	);

	rts_act #(.NR(NR), .NA(NA)) u_act (
		.bus (ifc.act_mp)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;

		tick = (s_q.div == '0);
		if (tick)
		begin
			s_d.div = DIV_W'(OP_DIV - 1);
		end
		else
		begin
			s_d.div = s_q.div - 1'b1;
		end

		unique case (exec_mode)
			rts_pkg::RTS_MODE_EVERY:  enabled = 1'b1;
			rts_pkg::RTS_MODE_SWITCH: enabled = run_control_switch;
			rts_pkg::RTS_MODE_FIRST:  enabled = s_q.first_pend;
			default:                  enabled = 1'b0;
		endcase
		go = tick && enabled;

		s_d.first_pend = ctrl_start ||
			(s_q.first_pend &&
			!(tick && exec_mode == rts_pkg::RTS_MODE_FIRST));

		low_step = rts_pkg::STEP_ALWAYS;
		for (int r = 0; r < NR; r++)
		begin
			if (rule_mask[r] &&
				rule_step[r] >= rts_pkg::STEP_FIRST &&
				rule_step[r] <= rts_pkg::STEP_LAST &&
				(low_step == rts_pkg::STEP_ALWAYS ||
				rule_step[r] < low_step))
			begin
				low_step = rule_step[r];
			end
		end

		if (s_q.run == rts_pkg::RTS_IDLE)
		begin
			eff_step = low_step;
			prev_eff = '0;
		end
		else
		begin
			eff_step = s_q.step;
			prev_eff = s_q.prev;
		end

		for (int r = 0; r < NR; r++)
		begin
			active[r] = rule_mask[r] &&
				(rule_step[r] == rts_pkg::STEP_ALWAYS ||
				(eff_step != rts_pkg::STEP_ALWAYS &&
				rule_step[r] == eff_step));
		end

		if (go)
		begin
			ifc.fire = ifc.cond & ~prev_eff & active;
		end
		else
		begin
			ifc.fire = '0;
		end

		jump = 1'b0;
		dest = eff_step;
		for (int r = NR - 1; r >= 0; r--)
		begin
			if (active[r] && ifc.cond[r] && then_en[r] &&
				then_step[r] >= rts_pkg::STEP_FIRST &&
				then_step[r] <= rts_pkg::STEP_LAST)
			begin
				jump = 1'b1;
				dest = then_step[r];
			end
			else if (active[r] && !ifc.cond[r] && else_en[r] &&
				else_step[r] >= rts_pkg::STEP_FIRST &&
				else_step[r] <= rts_pkg::STEP_LAST)
			begin
				jump = 1'b1;
				dest = else_step[r];
			end
		end

		s_d.exec  = go;
		s_d.fired = ifc.fire;

		unique case (s_q.run)
			rts_pkg::RTS_IDLE:
			begin
				if (go)
				begin
					s_d.run = rts_pkg::RTS_RUN;
				end
			end
			rts_pkg::RTS_RUN:
			begin
				if (tick && !enabled)
				begin
					s_d.run = rts_pkg::RTS_IDLE;
				end
			end
			default:
			begin
				s_d.run = rts_pkg::RTS_IDLE;
			end
		endcase

		if (go)
		begin
			s_d.act = ifc.act_new;
			s_d.prev = ifc.cond & active;
			s_d.step = dest;
			if (jump)
			begin
				for (int r = 0; r < NR; r++)
				begin
					if (rule_step[r] == dest)
					begin
						s_d.prev[r] = 1'b0;
					end
				end
			end
		end

		if (rule_expand && row_expand)
		begin
			s_d.slots = rts_pkg::SLOTS_BOTH;
		end
		else if (rule_expand || row_expand)
		begin
			s_d.slots = rts_pkg::SLOTS_ONE;
		end
		else
		begin
			s_d.slots = rts_pkg::SLOTS_STD;
		end
		addr_end = {1'b0, base_addr} + {8'h00, s_d.slots};
		s_d.next_addr = addr_end[9:0];
		s_d.addr_ok = (base_addr >= rts_pkg::ADDR_FIRST) &&
			(addr_end - 11'h001 <= {1'b0, rts_pkg::ADDR_LAST});
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q.div        <= '0;
			s_q.run        <= rts_pkg::RTS_IDLE;
			s_q.first_pend <= 1'b0;
			s_q.step       <= rts_pkg::STEP_RST;
			s_q.prev       <= '0;
			s_q.act        <= '0;
			s_q.fired      <= '0;
			s_q.exec       <= 1'b0;
			s_q.slots      <= rts_pkg::SLOTS_STD;
			s_q.next_addr  <= rts_pkg::ADDR_RST;
			s_q.addr_ok    <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign act_q       = s_q.act;
	assign step_q      = s_q.step;
	assign running_q   = s_q.run[1];
	assign exec_q      = s_q.exec;
	assign fired_q     = s_q.fired;
	assign slots_q     = s_q.slots;
	assign next_addr_q = s_q.next_addr;
	assign addr_ok_q   = s_q.addr_ok;

endmodule : rts_top
`default_nettype wire

// ==== tb/rts_assertions.sv ====
// rts_assertions: port-level checks of rts_top
// assumes one clock domain and OP_DIV of at least 3
`timescale 1ns/1ps
`default_nettype none
module rts_assertions #(
	parameter int unsigned NR     = 64,
	parameter int unsigned NA     = 64,
	parameter int unsigned OP_DIV = 100
) (
	input wire logic               clk,
	input wire logic               reset_n,
	input wire rts_pkg::rts_mode_t exec_mode,
	input wire logic               run_control_switch,
	input wire logic               rule_expand,
	input wire logic               row_expand,
	input wire logic [9:0]         base_addr,
	input wire logic [NA-1:0]      act_q,
	input wire logic [6:0]         step_q,
	input wire logic               running_q,
	input wire logic               exec_q,
	input wire logic [NR-1:0]      fired_q,
	input wire logic [2:0]         slots_q,
	input wire logic [9:0]         next_addr_q,
	input wire logic               addr_ok_q
);
	// ----
	// tick phase and sequences
	// ----
	logic [31:0] ph_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ph_q <= '0;
		else
			ph_q <= (ph_q == OP_DIV - 1) ? '0 : ph_q + 1;
	end
	sequence s_quiet;
		!exec_q [*2];
	endsequence
	sequence s_never;
		exec_mode == rts_pkg::RTS_MODE_NEVER;
	endsequence
	sequence s_sw_off;
		exec_mode == rts_pkg::RTS_MODE_SWITCH && !run_control_switch;
	endsequence
	fired_exec_a: assert property ((|fired_q) |-> exec_q)
		else $error("rule fired outside an execution");
	exec_phase_a: assert property (exec_q |-> ph_q == 1)
		else $error("execution off the operation tick");
	exec_gap_a: assert property (exec_q |=> s_quiet)
		else $error("executions too close");
	run_exec_a: assert property (exec_q |-> running_q)
		else $error("execution while not running");
	act_hold_a: assert property (!exec_q |-> $stable(act_q))
		else $error("actions changed between executions");
	step_hold_a: assert property (!exec_q |-> $stable(step_q))
		else $error("step changed between executions");
	step_range_a: assert property (step_q <= 7'h40)
		else $error("step number out of range");
	never_mode_a: assert property (s_never |=> !exec_q)
		else $error("execution in never mode");
	switch_off_a: assert property (s_sw_off |=> !exec_q)
		else $error("execution with switch off");
	slots_both_a: assert property (rule_expand && row_expand |=>
		slots_q == 3'h4)
		else $error("double expansion slot count");
	addr_next_a: assert property (1 |=>
		next_addr_q == $past(base_addr) + slots_q)
		else $error("next address wrong");
	addr_ok_a: assert property (1 |=> addr_ok_q ==
		($past(base_addr) >= 10'h2bd &&
		$past(base_addr) + slots_q - 1 <= 10'h384))
		else $error("address range flag wrong");
endmodule : rts_assertions
bind rts_top rts_assertions #(.NR(NR), .NA(NA), .OP_DIV(OP_DIV)) u_chk (
	.clk, .reset_n, .exec_mode, .run_control_switch, .rule_expand,
	.row_expand, .base_addr, .act_q, .step_q, .running_q, .exec_q,
	.fired_q, .slots_q, .next_addr_q, .addr_ok_q);
`default_nettype wire

// ==== tb/rts_contact_src.sv ====
// rts_contact_src: contacts of neighbouring function blocks
// assumes updates are requested at the falling edge
`timescale 1ns/1ps
`default_nettype none
module rts_contact_src (
	input  wire logic        clk,
	input  wire logic        upd,
	input  wire logic [63:0] val,
	output var  logic [63:0] contact_q
);
	// ----
	// contact levels, changed only on request
	// ----
	always_ff @(posedge clk)
	begin
		if (upd)
			contact_q <= val;
	end
endmodule : rts_contact_src
`default_nettype wire

// ==== tb/tb.sv ====
// tb: scenario bench for rts_top with a short operation cycle
// assumes the checker is bound to rts_top by its own file
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int unsigned OPD = 4;
	logic               clk, reset_n, sw, start, rx, wx, upd, run, ex, aok;
	rts_pkg::rts_mode_t mode;
	logic [9:0]         base, naddr;
	logic [63:0]        cval, ci, act, fired, ten, een;
	logic [63:0][63:0]  csel, cpol, asel, aval;
	logic [63:0][6:0]   rstep, tstep, estep;
	logic [6:0]         step;
	logic [2:0]         slots;
	int                 n_mismatch, tests_run, cyc;

	rts_contact_src u_src (.clk(clk), .upd(upd), .val(cval),
		.contact_q(ci));
	rts_top #(.OP_DIV(OPD)) u_dut (.clk(clk), .reset_n(reset_n),
		.exec_mode(mode), .run_control_switch(sw), .ctrl_start(start),
		.rule_expand(rx), .row_expand(wx), .base_addr(base),
		.contact_in(ci), .cond_sel(csel), .cond_pol(cpol),
		.act_sel(asel), .act_val(aval), .rule_step(rstep),
		.then_en(ten), .then_step(tstep), .else_en(een),
		.else_step(estep), .act_q(act), .step_q(step), .running_q(run),
		.exec_q(ex), .fired_q(fired), .slots_q(slots),
		.next_addr_q(naddr), .addr_ok_q(aok));

	// ----
	// helpers
	// ----
	task automatic chk(input logic [63:0] got, exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s %h not %h", $time, what,
				got, exp);
		end
	endtask : chk
	task automatic cfg(input int r, input logic [6:0] s,
		input logic [7:0] cs, cp, as, av, input logic [6:0] t);
		csel[r] = {56'h0, cs};
		cpol[r] = {56'h0, cp};
		asel[r] = {56'h0, as};
		aval[r] = {56'h0, av};
		rstep[r] = s;
		ten[r] = (t != 7'h0);
		tstep[r] = t;
	endtask : cfg
	task automatic wait_exec;
		@(negedge clk);
		repeat (3 * OPD)
			if (ex !== 1'b1)
				@(negedge clk);
		chk(ex, 1, "exec");
	endtask : wait_exec
	task automatic set_c(input logic [63:0] v);
		@(negedge clk);
		cval = v;
		upd = 1;
		@(negedge clk);
		upd = 0;
	endtask : set_c
	task automatic cnt_exec(input int n, output int c);
		c = 0;
		repeat (n)
		begin
			@(negedge clk);
			if (ex === 1'b1)
				c++;
		end
	endtask : cnt_exec

	// ----
	// scenarios
	// ----
	task automatic t_steps;
		wait_exec;
		chk(fired, 3, "start fired");
		chk(step, 4, "start step");
		chk(act, 3, "start act");
		wait_exec;
		chk(fired, 64'h14, "entry fired");
		chk(act, 3, "conflict act");
		chk(step, 6, "branch step");
		wait_exec;
		chk(fired, 0, "held cond");
		set_c(64'h2);
		wait_exec;
		set_c(64'h3);
		wait_exec;
		chk(fired, 1, "re-rise");
	endtask : t_steps
	task automatic t_restart;
		mode = rts_pkg::RTS_MODE_NEVER;
		repeat (2 * OPD) @(negedge clk);
		chk(run, 0, "stopped");
		chk(act, 3, "held act");
		mode = rts_pkg::RTS_MODE_EVERY;
		wait_exec;
		chk(step, 4, "restart step");
		chk(fired, 3, "restart fired");
	endtask : t_restart
	task automatic t_switch;
		int c;
		mode = rts_pkg::RTS_MODE_SWITCH;
		cnt_exec(3 * OPD, c);
		chk(c, 0, "switch off");
		sw = 1;
		cnt_exec(2 * OPD, c);
		chk(c, 2, "switch on");
		sw = 0;
	endtask : t_switch
	task automatic t_first;
		int a, b;
		mode = rts_pkg::RTS_MODE_FIRST;
		cnt_exec(3 * OPD, a);
		chk(a, 0, "unarmed");
		start = 1;
		cnt_exec(1, a);
		start = 0;
		cnt_exec(4 * OPD, b);
		chk(a + b, 1, "once");
	endtask : t_first
	task automatic t_slots;
		logic [9:0] b [4];
		logic [2:0] s;
		b = '{10'h2bc, 10'h2bd, 10'h383, 10'h384};
		for (int i = 0; i < 4; i++)
		begin
			rx = i[0];
			wx = i[1];
			base = b[i];
			s = (rx && wx) ? 3'h4 : (rx || wx) ? 3'h2 : 3'h1;
			@(negedge clk);
			chk(slots, s, "slots");
			chk(naddr, base + s, "next addr");
			chk(aok, base >= 10'h2bd && base + s - 1 <= 10'h384, "ok");
		end
	endtask : t_slots
	task automatic t_expand;
		rx = 1'b0;
		wx = 1'b0;
		een[1] = 1'b1;
		estep[1] = 7'h9;
		cfg(6, 7'h9, 8'h1, 8'h1, 8'h0, 8'h0, 7'h0);
		asel[6][40] = 1'b1;
		aval[6][40] = 1'b1;
		cfg(32, 7'h9, 8'h1, 8'h1, 8'h20, 8'h20, 7'h0);
		set_c(64'h1);
		mode = rts_pkg::RTS_MODE_EVERY;
		wait_exec;
		chk(step, 9, "else step");
		chk(fired, 1, "else fired");
		wait_exec;
		chk(fired, 64'h60, "narrow fired");
		chk(act, 64'h13, "narrow act");
		rx = 1'b1;
		wx = 1'b1;
		set_c(64'h0);
		wait_exec;
		set_c(64'h1);
		wait_exec;
		chk(fired, 64'h1_0000_0061, "wide fired");
		chk(act, 64'h100_0000_0033, "wide act");
	endtask : t_expand

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_mismatch++;
			report_and_stop;
		end
	end
	initial
	begin
		{reset_n, sw, start, rx, wx} = '0;
		{csel, cpol, asel, aval, rstep, tstep, estep, ten, een} = '0;
		mode = rts_pkg::RTS_MODE_EVERY;
		base = 10'h2bd;
		cval = 64'h3;
		upd = 1;
		cfg(0, 7'h0, 8'h1, 8'h1, 8'h1, 8'h1, 7'h0);
		cfg(1, 7'h2, 8'h2, 8'h2, 8'h2, 8'h2, 7'h4);
		cfg(2, 7'h4, 8'h6, 8'h2, 8'h2, 8'h0, 7'h6);
		cfg(3, 7'h4, 8'h0, 8'h0, 8'h8, 8'h8, 7'h0);
		cfg(4, 7'h4, 8'h4, 8'h0, 8'h2, 8'h2, 7'h2);
		cfg(5, 7'h9, 8'h1, 8'h1, 8'h10, 8'h10, 7'h0);
		repeat (8) @(negedge clk);
		chk(slots, 1, "reset slots");
		chk(naddr, 10'h2bd, "reset addr");
		reset_n = 1;
		upd = 0;
		t_steps;
		t_restart;
		t_switch;
		t_first;
		t_slots;
		t_expand;
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
